/* File: verilog/ptpc_device.sv */
// Timestamping datapath end: timer decode, per-frame operations,
// one-step adjustment and the tag FIFO with sticky error flags.
// Assumes the client drives every link input on this same clock.
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R1) Normal RX timer: 48 seconds, 32 nanoseconds
// (R2) Transparent: bits 62:16 ns, 15:0 fraction
// (R3) Client keeps timer bit 63 zero
// (R4) Client drives RX timer on lane clock
// (R5) One-step enable high allows one-step operation
// (R6) One-step adds 11-bit latency adjust value
// (R7) Control pins exist without register interface
// (R8) Transparent mode: timer is a correction
// (R9) Transparent TX adds correction to timestamp
// (R10) Correction sign bit taken as zero
// (R11) Client pre-adjusts frame correction field
// (R12) Flag set on tag write error
// (R13) Flag set on tag read error
// (R14) Flags stay until TX path reset
// (R15) Opcode 00: no timestamp, frame untouched
// (R16) Opcode 01: capture and insert timestamp
// (R17) Opcode 10: capture and return timestamp
// (R18) Opcode 11 behaves as no operation
// (R19) Client drives TX timer on TX clock
// (R20) Tag returned with one- and two-step stamps
// (R21) Opcode and tag valid with start word
module ptpc_device
  import ptpc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Link to client
  ptpc_link_if.device link
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic wr_err;
    logic rd_err;
    logic rx_valid;
    logic [47:0] rx_secs;
    logic [47:0] rx_ns;
    logic [15:0] rx_frac;
    logic ins_valid;
    logic [TS_W-1:0] ins_ts;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic [DEPTH-1:0][ENTRY_W-1:0] mem;
  } ptpc_dev_st_t;

  ptpc_dev_st_t s;
  ptpc_dev_st_t next_s;

  // Decoded transmit side values
  logic [CORR_W-1:0] corr;
  logic [CORR_W-1:0] tc_sum;
  logic [CORR_W-1:0] tc_adj;
  logic [32:0] ns_sum;
  logic [47:0] secs_adj;
  logic [31:0] ns_adj;
  logic [TS_W-1:0] two_step_ts;
  logic [TS_W-1:0] one_step_ts;
  logic do_one;
  logic do_two;
  logic push;
  logic pop;

  always_comb begin
    // Sign bit forced clear, so the residence correction never goes negative
    corr = {1'b0, link.tx_timer[TC_NS_MSB:0]}; // (R10)
    // Frame correction plus residence correction
    tc_sum = link.frame_correction + corr; // (R8) (R9)
    // Latency moved onto the 16-bit fraction grid
    tc_adj = tc_sum
      + (CORR_W'(link.latency_adjust) << ADJ_FRAC_SHIFT); // (R6)
    // Normal format only resolves whole nanoseconds
    ns_sum = {1'b0, link.tx_timer[SEC_LSB-1:0]}
      + {25'h0, link.latency_adjust[ADJ_W-1:ADJ_NS_LSB]}; // (R6)
    // One carry is enough: the adjust is far below a second
    if (ns_sum >= NS_PER_SEC) begin
      ns_adj = 32'(ns_sum - NS_PER_SEC);
      secs_adj = link.tx_timer[TS_W-1:SEC_LSB] + 48'h1;
    end else begin
      ns_adj = ns_sum[31:0];
      secs_adj = link.tx_timer[TS_W-1:SEC_LSB];
    end
    if (link.transp_mode) begin
      two_step_ts = {16'h0, tc_sum}; // (R9)
      one_step_ts = {16'h0, tc_adj};
    end else begin
      two_step_ts = link.tx_timer;
      one_step_ts = {secs_adj, ns_adj};
    end
  end

  always_comb begin
    // Opcode sampled only with the start word
    do_one = 1'b0;
    do_two = 1'b0;
    if (link.tx_sop) begin // (R21)
      case (link.frame_timestamp_opcode)
        OP_ONE_STEP: begin
          // Pin gates one-step; the client's CTRL register bit drives the pin
          do_one = link.one_step_timestamp_enable; // (R5) (R7) (R16)
        end
        OP_TWO_STEP: begin
          do_two = 1'b1; // (R17)
        end
        OP_RESERVED: begin
          do_one = 1'b0; // (R18)
        end
        default: begin
          do_one = 1'b0; // (R15)
        end
      endcase
    end
    push = do_one | do_two; // (R20)
    pop = link.ts_ack;
  end

  always_comb begin
    next_s = s;
    next_s.rx_valid = 1'b0;
    next_s.ins_valid = 1'b0;
    // Receive timer decode on each receive start word
    if (link.rx_sop) begin
      next_s.rx_valid = 1'b1;
      if (link.transp_mode) begin
        next_s.rx_secs = 48'h0;
        next_s.rx_ns = {1'b0, link.rx_timer[TC_NS_MSB:TC_NS_LSB]}; // (R2)
        next_s.rx_frac = link.rx_timer[TC_NS_LSB-1:0]; // (R2)
      end else begin
        next_s.rx_secs = link.rx_timer[TS_W-1:SEC_LSB]; // (R1)
        next_s.rx_ns = {16'h0, link.rx_timer[SEC_LSB-1:0]}; // (R1)
        next_s.rx_frac = 16'h0;
      end
    end
    // Inserted value for the outgoing frame
    if (do_one) begin
      next_s.ins_valid = 1'b1; // (R16)
      next_s.ins_ts = one_step_ts; // (R16)
    end
    // Tag FIFO; a pop and a push may share a cycle
    // A full push with a same-cycle pop frees its own slot
    if (pop && s.count == '0) begin
      next_s.rd_err = 1'b1; // (R13)
    end
    if (push && s.count == FULL_CNT && !(pop && s.count != '0)) begin
      next_s.wr_err = 1'b1; // (R12)
    end
    if (pop && s.count != '0) begin
      next_s.rptr = (s.rptr == LAST_PTR) ? '0 : s.rptr + AW'(1);
    end
    if (push && (s.count != FULL_CNT || pop)) begin
      next_s.mem[s.wptr] = {link.tx_tag,
        do_one ? one_step_ts : two_step_ts}; // (R20)
      next_s.wptr = (s.wptr == LAST_PTR) ? '0 : s.wptr + AW'(1);
    end
    if (push && !(pop && s.count != '0) && s.count != FULL_CNT) begin
      next_s.count = s.count + CW'(1);
    end else if (!push && pop && s.count != '0) begin
      next_s.count = s.count - CW'(1);
    end
    // Path reset empties the FIFO and clears flags
    // It outranks a same-cycle error, so a push there is lost too
    if (link.tx_path_reset) begin
      next_s.wr_err = 1'b0; // (R14)
      next_s.rd_err = 1'b0; // (R14)
      next_s.wptr = '0;
      next_s.rptr = '0;
      next_s.count = '0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // Outputs
  assign link.ts_valid = (s.count != '0);
  assign link.ts_tag = s.mem[s.rptr][ENTRY_W-1:TS_W]; // (R20)
  assign link.ts_value = s.mem[s.rptr][TS_W-1:0]; // (R17)
  assign link.insert_valid = s.ins_valid;
  assign link.insert_ts = s.ins_ts;
  assign link.fifo_write_error = s.wr_err;
  assign link.fifo_read_error = s.rd_err;
  assign link.rx_ts_valid = s.rx_valid;
  assign link.rx_seconds = s.rx_secs;
  assign link.rx_nanoseconds = s.rx_ns;
  assign link.rx_fraction = s.rx_frac;

endmodule : ptpc_device
`default_nettype wire

/* File: verilog/ptpc_pkg.sv */
// Shared constants for the timestamp control link and its register map.
// Assumes one 20 MHz clock shared by both ends of the link.
package ptpc_pkg;
  // Widths
  localparam int TS_W = 80;
  localparam int TAG_W = 16;
  localparam int ADJ_W = 11;
  localparam int CORR_W = 64;
  localparam int ENTRY_W = TAG_W + TS_W;
  // Timer field positions
  localparam int SEC_LSB = 32;
  localparam int TC_SIGN_BIT = 63;
  localparam int TC_NS_MSB = 62;
  localparam int TC_NS_LSB = 16;
  localparam int ADJ_NS_LSB = 3;
  localparam int ADJ_FRAC_SHIFT = TC_NS_LSB - ADJ_NS_LSB;
  // Frame operation codes
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_ONE_STEP = 2'h1;
  localparam logic [1:0] OP_TWO_STEP = 2'h2;
  localparam logic [1:0] OP_RESERVED = 2'h3;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam logic [32:0] NS_PER_SEC = 33'h03b9aca00;
  localparam logic [32:0] NS_PER_CLK = 33'(CLK_PERIOD_NS);
  // Tag FIFO depth default
  localparam int FIFO_DEPTH = 4;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX_CMD = 8'h04;
  localparam logic [7:0] REG_RX_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_TS_TAG = 8'h10;
  localparam logic [7:0] REG_TS_LO = 8'h14;
  localparam logic [7:0] REG_TS_MID = 8'h18;
  localparam logic [7:0] REG_TS_HI = 8'h1c;
  localparam logic [7:0] REG_CORR = 8'h20;
  localparam logic [7:0] REG_FCORR = 8'h24;
  localparam logic [7:0] REG_INS_LO = 8'h28;
  localparam logic [7:0] REG_RX_NS = 8'h30;
  localparam logic [7:0] REG_RX_SEC = 8'h34;
  localparam logic [7:0] REG_RX_FRAC = 8'h38;
  // Control and command register fields
  localparam int CTRL_TRANSP = 0;
  localparam int CTRL_ONE_STEP = 1;
  localparam int CTRL_PATH_RST = 2;
  localparam int CTRL_ADJ_LSB = 16;
  localparam int CMD_TAG_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0;
endpackage : ptpc_pkg

/* File: verilog/ptpc_link_if.sv */
// Link between the client logic and the timestamping datapath.
// Both ends run on the same clock; the bench joins them.
`timescale 1ns/1ps
`default_nettype none
interface ptpc_link_if;
  import ptpc_pkg::*;
  logic [TS_W-1:0] tx_timer;
  logic [TS_W-1:0] rx_timer;
  logic transp_mode;
  logic one_step_timestamp_enable;
  logic [ADJ_W-1:0] latency_adjust;
  logic tx_path_reset;
  logic tx_sop;
  logic [1:0] frame_timestamp_opcode;
  logic [TAG_W-1:0] tx_tag;
  logic [CORR_W-1:0] frame_correction;
  logic rx_sop;
  logic ts_ack;
  logic ts_valid;
  logic [TAG_W-1:0] ts_tag;
  logic [TS_W-1:0] ts_value;
  logic insert_valid;
  logic [TS_W-1:0] insert_ts;
  logic fifo_write_error;
  logic fifo_read_error;
  logic rx_ts_valid;
  logic [47:0] rx_seconds;
  logic [47:0] rx_nanoseconds;
  logic [15:0] rx_fraction;
  modport device (
    input tx_timer, rx_timer, transp_mode, one_step_timestamp_enable,
    input latency_adjust, tx_path_reset, tx_sop, frame_timestamp_opcode,
    input tx_tag, frame_correction, rx_sop, ts_ack,
    output ts_valid, ts_tag, ts_value, insert_valid, insert_ts,
    output fifo_write_error, fifo_read_error, rx_ts_valid,
    output rx_seconds, rx_nanoseconds, rx_fraction
  );
  modport client (
    output tx_timer, rx_timer, transp_mode, one_step_timestamp_enable,
    output latency_adjust, tx_path_reset, tx_sop, frame_timestamp_opcode,
    output tx_tag, frame_correction, rx_sop, ts_ack,
    input ts_valid, ts_tag, ts_value, insert_valid, insert_ts,
    input fifo_write_error, fifo_read_error, rx_ts_valid,
    input rx_seconds, rx_nanoseconds, rx_fraction
  );
endinterface : ptpc_link_if
`default_nettype wire

/* File: verilog/ptpc_client.sv */
// Client end: timer source, frame commands and status, all reached
// over a classic Wishbone slave. Assumes the device on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ptpc_client
  import ptpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link to device
  ptpc_link_if.client link
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic path_rst;
    logic tx_sop;
    logic [1:0] op;
    logic [TAG_W-1:0] tag;
    logic rx_sop;
    logic ts_ack;
    logic [31:0] corr;
    logic [31:0] fcorr;
    logic [47:0] secs;
    logic [31:0] ns;
    logic ack;
    logic [31:0] dat;
  } ptpc_cli_st_t;

  ptpc_cli_st_t s;
  ptpc_cli_st_t next_s;
  logic [31:0] mask;
  logic [31:0] rdata;
  logic take;
  logic [32:0] ns_next;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
    take = wb_cyc_i & wb_stb_i & ~s.ack;
    ns_next = {1'b0, s.ns} + NS_PER_CLK;
  end

  always_comb begin
    if (wb_adr_i == REG_CTRL) begin
      rdata = s.ctrl;
    end else if (wb_adr_i == REG_STATUS) begin
      rdata = {29'h0, link.ts_valid, link.fifo_read_error,
        link.fifo_write_error};
    end else if (wb_adr_i == REG_TS_TAG) begin
      rdata = {16'h0, link.ts_tag};
    end else if (wb_adr_i == REG_TS_LO) begin
      rdata = link.ts_value[31:0];
    end else if (wb_adr_i == REG_TS_MID) begin
      rdata = link.ts_value[63:32];
    end else if (wb_adr_i == REG_TS_HI) begin
      rdata = {16'h0, link.ts_value[79:64]};
    end else if (wb_adr_i == REG_CORR) begin
      rdata = s.corr;
    end else if (wb_adr_i == REG_FCORR) begin
      rdata = s.fcorr;
    end else if (wb_adr_i == REG_INS_LO) begin
      rdata = link.insert_ts[31:0];
    end else if (wb_adr_i == REG_RX_NS) begin
      rdata = link.rx_nanoseconds[31:0];
    end else if (wb_adr_i == REG_RX_SEC) begin
      rdata = link.rx_seconds[31:0];
    end else if (wb_adr_i == REG_RX_FRAC) begin
      rdata = {16'h0, link.rx_fraction};
    end else begin
      rdata = 32'h0;
    end
  end

  always_comb begin
    next_s = s;
    next_s.path_rst = 1'b0;
    next_s.tx_sop = 1'b0;
    next_s.rx_sop = 1'b0;
    next_s.ts_ack = 1'b0;
    next_s.ack = take;
    // Free running time of day, one period per clock
    if (ns_next >= NS_PER_SEC) begin
      next_s.ns = 32'(ns_next - NS_PER_SEC);
      next_s.secs = s.secs + 48'h1;
    end else begin
      next_s.ns = ns_next[31:0];
    end
    if (take) begin
      next_s.dat = wb_we_i ? 32'h0 : rdata;
    end
    if (take && wb_we_i) begin
      if (wb_adr_i == REG_CTRL) begin
        next_s.ctrl = (s.ctrl & ~mask) | (wb_dat_i & mask);
        // Reset bit self-clears and acts for one cycle
        next_s.path_rst = wb_dat_i[CTRL_PATH_RST]; // (R14)
        next_s.ctrl[CTRL_PATH_RST] = 1'b0;
      end else if (wb_adr_i == REG_TX_CMD) begin
        // Opcode and tag issued with the start word
        next_s.tx_sop = 1'b1; // (R21)
        next_s.op = wb_dat_i[1:0];
        next_s.tag = wb_dat_i[CMD_TAG_LSB +: TAG_W];
      end else if (wb_adr_i == REG_RX_CMD) begin
        next_s.rx_sop = 1'b1;
      end else if (wb_adr_i == REG_TS_TAG) begin
        next_s.ts_ack = 1'b1;
      end else if (wb_adr_i == REG_CORR) begin
        next_s.corr = (s.corr & ~mask) | (wb_dat_i & mask);
      end else if (wb_adr_i == REG_FCORR) begin
        // Software writes the already adjusted field
        next_s.fcorr = (s.fcorr & ~mask) | (wb_dat_i & mask); // (R11)
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // Single clock: both timers share the local time base
  always_comb begin
    if (s.ctrl[CTRL_TRANSP]) begin
      link.tx_timer = {16'h0, 1'b0, 31'h0, s.corr}; // (R3) (R19)
    end else begin
      link.tx_timer = {s.secs, s.ns}; // (R19)
    end
    link.rx_timer = link.tx_timer; // (R4)
  end

  assign link.transp_mode = s.ctrl[CTRL_TRANSP];
  assign link.one_step_timestamp_enable = s.ctrl[CTRL_ONE_STEP];
  assign link.latency_adjust = s.ctrl[CTRL_ADJ_LSB +: ADJ_W];
  assign link.tx_path_reset = s.path_rst;
  assign link.tx_sop = s.tx_sop;
  assign link.frame_timestamp_opcode = s.op;
  assign link.tx_tag = s.tag;
  assign link.frame_correction = {32'h0, s.fcorr};
  assign link.rx_sop = s.rx_sop;
  assign link.ts_ack = s.ts_ack;
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;

endmodule : ptpc_client
`default_nettype wire

/* File: testbench/ptpc_link_props.sv */
// Checker for the timestamp control link.
// Assumes one clock; the bench places it beside the link.
`timescale 1ns/1ps
`default_nettype none
module ptpc_link_props
  import ptpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Client side
  input wire logic [TS_W-1:0] tx_timer,
  input wire logic [TS_W-1:0] rx_timer,
  input wire logic transp_mode,
  input wire logic one_step_timestamp_enable,
  input wire logic tx_path_reset,
  input wire logic tx_sop,
  input wire logic [1:0] frame_timestamp_opcode,
  input wire logic [TAG_W-1:0] tx_tag,
  input wire logic [CORR_W-1:0] frame_correction,
  input wire logic rx_sop,
  input wire logic ts_ack,
  // Device side
  input wire logic ts_valid,
  input wire logic [TAG_W-1:0] ts_tag,
  input wire logic [TS_W-1:0] ts_value,
  input wire logic insert_valid,
  input wire logic fifo_write_error,
  input wire logic fifo_read_error,
  input wire logic rx_ts_valid,
  input wire logic [47:0] rx_seconds,
  input wire logic [47:0] rx_nanoseconds,
  input wire logic [15:0] rx_fraction
);
  logic [TS_W-1:0] tq;
  logic [TS_W-1:0] rq;
  logic [CORR_W-1:0] fq;
  // Inputs as seen at the start edge
  always_ff @(posedge clk_i) begin
    tq <= tx_timer;
    rq <= rx_timer;
    fq <= frame_correction;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_op(logic [1:0] op);
    tx_sop && frame_timestamp_opcode == op && !tx_path_reset;
  endsequence
  sequence s_fresh_two;
    s_op(OP_TWO_STEP) ##0 !ts_valid;
  endsequence
  property p_norm;
    s_fresh_two ##0 !transp_mode |=> ts_value == tq &&
      ts_tag == $past(tx_tag);
  endproperty
  a_norm: assert property (p_norm)
    else $error("two-step stamp or tag wrong");
  property p_corr;
    s_fresh_two ##0 transp_mode |=>
      ts_value == {16'h0, fq + {1'b0, tq[62:0]}};
  endproperty
  a_corr: assert property (p_corr)
    else $error("corrected stamp wrong");
  property p_none;
    tx_sop && (frame_timestamp_opcode[0] == frame_timestamp_opcode[1])
      && !ts_valid && !ts_ack |=> !ts_valid && !insert_valid;
  endproperty
  a_none: assert property (p_none)
    else $error("no-op frame stamped");
  property p_one;
    s_op(OP_ONE_STEP) ##0 one_step_timestamp_enable |=> insert_valid;
  endproperty
  a_one: assert property (p_one)
    else $error("one-step insert missing");
  property p_off;
    s_op(OP_ONE_STEP) ##0 !one_step_timestamp_enable |=> !insert_valid;
  endproperty
  a_off: assert property (p_off)
    else $error("one-step while disabled");
  property p_rerr;
    ts_ack && !ts_valid && !tx_path_reset |=> fifo_read_error;
  endproperty
  a_rerr: assert property (p_rerr)
    else $error("empty pop not flagged");
  property p_wkeep;
    fifo_write_error && !tx_path_reset |=> fifo_write_error;
  endproperty
  a_wkeep: assert property (p_wkeep)
    else $error("write flag dropped");
  property p_rkeep;
    fifo_read_error && !tx_path_reset |=> $stable(fifo_read_error);
  endproperty
  a_rkeep: assert property (p_rkeep)
    else $error("read flag dropped");
  property p_clr;
    tx_path_reset |=> !fifo_read_error && !fifo_write_error && !ts_valid;
  endproperty
  a_clr: assert property (p_clr)
    else $error("path reset left state");
  property p_rxn;
    rx_sop && !transp_mode |=> rx_ts_valid &&
      rx_seconds == rq[79:32] && rx_nanoseconds == {16'h0, rq[31:0]};
  endproperty
  a_rxn: assert property (p_rxn)
    else $error("rx normal decode wrong");
  property p_rxt;
    rx_sop && transp_mode |=> rx_ts_valid &&
      rx_nanoseconds == {1'b0, rq[62:16]} && rx_fraction == rq[15:0];
  endproperty
  a_rxt: assert property (p_rxt)
    else $error("rx transparent decode wrong");
endmodule : ptpc_link_props
`default_nettype wire

/* File: testbench/tb_ptp_timestamp_control.sv */
// Bench: drives the client over Wishbone; the device answers.
// Assumes a tag FIFO of depth 2, so two frames fill it.
`timescale 1ns/1ps
`default_nettype none
module tb_ptp_timestamp_control;
  import ptpc_pkg::*;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
  } ptpc_row_t;
  logic clk_i;
  logic reset_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] rd;
  logic [31:0] t0;
  logic ce_i;
  int mismatches;
  int comparisons;
  ptpc_row_t rows [25];
  ptpc_link_if link();
  ptpc_client ptpc_client_i (.clk_i(clk_i), .reset_i(reset_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link(link));
  ptpc_device #(.DEPTH(2)) ptpc_device_i (.clk_i(clk_i),
    .reset_i(reset_i), .ce_i(ce_i), .link(link));
  ptpc_link_props ptpc_link_props_i (.clk_i(clk_i), .reset_i(reset_i),
    .tx_timer(link.tx_timer), .rx_timer(link.rx_timer),
    .transp_mode(link.transp_mode),
    .one_step_timestamp_enable(link.one_step_timestamp_enable),
    .tx_path_reset(link.tx_path_reset), .tx_sop(link.tx_sop),
    .frame_timestamp_opcode(link.frame_timestamp_opcode),
    .tx_tag(link.tx_tag), .frame_correction(link.frame_correction),
    .rx_sop(link.rx_sop), .ts_ack(link.ts_ack),
    .ts_valid(link.ts_valid), .ts_tag(link.ts_tag),
    .ts_value(link.ts_value), .insert_valid(link.insert_valid),
    .fifo_write_error(link.fifo_write_error),
    .fifo_read_error(link.fifo_read_error),
    .rx_ts_valid(link.rx_ts_valid), .rx_seconds(link.rx_seconds),
    .rx_nanoseconds(link.rx_nanoseconds),
    .rx_fraction(link.rx_fraction));
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t read %h want %h", $time, seen, exp);
    end
  endtask : check
  // Entered just after a rising edge; leaves one idle cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    mismatches = 0;
    comparisons = 0;
    // Transparent mode keeps the timer fixed, so stamps are exact
    rows = '{'{1'b1, REG_CTRL, 32'h07ff0003},
      '{1'b1, REG_CORR, 32'h00021234}, '{1'b1, REG_FCORR, 32'hffff0000},
      '{1'b0, REG_CTRL, 32'h07ff0003}, '{1'b1, REG_TX_CMD, 32'ha5a50002},
      '{1'b0, REG_STATUS, 32'h4}, '{1'b0, REG_TS_TAG, 32'h0000a5a5},
      '{1'b0, REG_TS_LO, 32'h00011234}, '{1'b0, REG_TS_MID, 32'h1},
      '{1'b0, REG_TS_HI, 32'h0}, '{1'b1, REG_TS_TAG, 32'h0},
      '{1'b0, REG_STATUS, 32'h0}, '{1'b1, REG_TX_CMD, 32'h11110001},
      '{1'b0, REG_INS_LO, 32'h0100f234}, '{1'b0, REG_TS_TAG, 32'h1111},
      '{1'b0, REG_TS_LO, 32'h0100f234}, '{1'b1, REG_TS_TAG, 32'h0},
      '{1'b1, REG_TX_CMD, 32'h22220000}, '{1'b1, REG_TX_CMD, 32'h33330003},
      '{1'b0, REG_STATUS, 32'h0}, '{1'b1, REG_RX_CMD, 32'h0},
      '{1'b0, REG_RX_NS, 32'h2}, '{1'b0, REG_RX_FRAC, 32'h1234},
      '{1'b0, REG_RX_SEC, 32'h0}, '{1'b0, 8'h3c, 32'h0}};
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) begin
        check(rd, rows[i].dat);
      end
    end
    wb(1'b1, REG_TS_TAG, 32'h0);
    rdc(REG_STATUS, 32'h2);
    repeat (3) wb(1'b1, REG_TX_CMD, 32'h00070002);
    rdc(REG_STATUS, 32'h7);
    wb(1'b1, REG_CTRL, 32'h07ff0007);
    rdc(REG_STATUS, 32'h0);
    rdc(REG_CTRL, 32'h07ff0003);
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b1, REG_TX_CMD, 32'h00090001);
    rdc(REG_STATUS, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b1, REG_TX_CMD, 32'h00080002);
    wb(1'b1, REG_RX_CMD, 32'h0);
    rdc(REG_TS_TAG, 32'h8);
    // Normal one-step: stamp gap is three enabled clock periods plus latency ns
    wb(1'b1, REG_TS_TAG, 32'h0);
    wb(1'b1, REG_CTRL, 32'h07ff0002);
    wb(1'b1, REG_TX_CMD, 32'h000b0002);
    // Frozen cycles must not advance the time base
    ce_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    wb(1'b1, REG_TX_CMD, 32'h000c0001);
    wb(1'b0, REG_TS_LO, 32'h0);
    t0 = rd;
    wb(1'b1, REG_TS_TAG, 32'h0);
    rdc(REG_TS_TAG, 32'hc);
    wb(1'b0, REG_TS_LO, 32'h0);
    check(rd - t0, 32'(3 * CLK_PERIOD_NS + (11'h7ff >> ADJ_NS_LSB)));
    rdc(REG_INS_LO, rd);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rdc(REG_STATUS, 32'h0);
    rdc(REG_CTRL, 32'h0);
    complete_run();
  end
endmodule : tb_ptp_timestamp_control
`default_nettype wire
